// ### lcdg_defines.svh
// Constants for the LCD-shared general-purpose port pair.
// Assumes an 8-bit register port with byte offsets and one 10 MHz clock.
`ifndef LCDG_DEFINES_SVH
`define LCDG_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LCDG_ADDR_W          8
`define LCDG_OFS_PA_DATA     8'h00
`define LCDG_OFS_PA_DIR      8'h01
`define LCDG_OFS_PB_DATA     8'h02
`define LCDG_OFS_PB_DIR      8'h03
`define LCDG_OFS_LCD_EN1     8'h04
`define LCDG_OFS_LCD_EN2     8'h05
`define LCDG_OFS_LCD_EN3     8'h06
`define LCDG_OFS_LCD_EN7     8'h07
`define LCDG_OFS_STBY_CTL    8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LCDG_IN_CTL_BIT      0
`define LCDG_FLOAT_BIT       0
`define LCDG_COL_LOW_MSB     1
`define LCDG_COL_HIGH_MSB    2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LCDG_RST_DIR_A       8'h00
`define LCDG_RST_DIR_B       5'h00
`define LCDG_RST_DATA_A      8'h00
`define LCDG_RST_DATA_B      5'h00
`define LCDG_RST_CTRL        8'h00

`endif

// ### lcdg_pin_model.sv
// Model of the board pins beside the port pair.
// Assumes the bench sets the level that outside parts put on undriven pins.
module lcdg_pin_model (
  input  wire lcdg_pkg::lcdg_byte_t PA_OUT,
  input  wire lcdg_pkg::lcdg_byte_t PA_OE,
  input  wire lcdg_pkg::lcdg_byte_t EXT_A,
  output lcdg_pkg::lcdg_byte_t      PA_IN,
  input  wire lcdg_pkg::lcdg_pb_t   PB_OUT,
  input  wire lcdg_pkg::lcdg_pb_t   PB_OE,
  input  wire lcdg_pkg::lcdg_pb_t   EXT_B,
  output lcdg_pkg::lcdg_pb_t        PB_IN
);
  import lcdg_pkg::*;
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Driven bits read back the drive, others the outside level
  assign PA_IN = (PA_OUT & PA_OE) | (EXT_A & ~PA_OE);
  assign PB_IN = (PB_OUT & PB_OE) | (EXT_B & ~PB_OE);
endmodule // lcdg_pin_model

// ### lcdg_pkg.sv
// Types shared by the LCD-shared port pair.
// Assumes lcdg_defines.svh supplies the numeric constants.
package lcdg_pkg;

  // ----------------------------------------------------------------
  // Data widths
  // ----------------------------------------------------------------
  typedef logic [7:0] lcdg_byte_t;
  typedef logic [4:0] lcdg_pb_t;

endpackage : lcdg_pkg

// ### lcdg_ports.sv
// Two general-purpose ports whose pins are shared with the LCD driver unit.
// Assumes the LCD driver unit and the standby controller run on CLK_SYS;
// pin inputs arrive asynchronously and are synchronised here.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`include "lcdg_defines.svh"

// Operation
// - A direction bit of 1 makes its pin an output driven from the data latch bit.
// - A direction bit of 0 makes its pin an input that the latch does not drive.
// - A data write updates the latch and shows on pins set as outputs one clock after the latch.
// - A data write updates the latch for input bits too, without driving their pins.
// - Reading data returns the latch for bits set as outputs.
// - Reading data returns the pin for input bits while input control is set (low if clear), but the latch on a read-modify-write.
// - Backplane select bit 0 gives the port A pin to the port, 1 to the LCD, input control set.
// - Column select bit 0 gives the port B pin to the port, 1 to the LCD, input control set.
// - Reset clears every direction bit, leaving all pins as inputs.
// - With the float bit set in stop or watch mode pins float and inputs read low.
// - With the float bit clear in stop or watch mode pins keep their drive and level.
// - Port B has bits four to zero and port A bits seven to zero, each on its own pin.
module lcdg_ports (
  input  wire logic           CLK_SYS,
  input  wire logic           RESETN,
  input  wire logic [7:0]     ADDR,
  input  wire lcdg_pkg::lcdg_byte_t WDATA,
  input  wire logic           WR,
  input  wire logic           RD,
  input  wire logic           RMW,
  output lcdg_pkg::lcdg_byte_t      RDATA,
  input  wire logic           STBY_MODE,
  input  wire lcdg_pkg::lcdg_byte_t LCD_COM_LVL,
  input  wire lcdg_pkg::lcdg_pb_t   LCD_SEG_LVL,
  input  wire lcdg_pkg::lcdg_byte_t PA_IN,
  output lcdg_pkg::lcdg_byte_t      PA_OUT,
  output lcdg_pkg::lcdg_byte_t      PA_OE,
  output lcdg_pkg::lcdg_byte_t      PA_IN_VAL,
  input  wire lcdg_pkg::lcdg_pb_t   PB_IN,
  output lcdg_pkg::lcdg_pb_t        PB_OUT,
  output lcdg_pkg::lcdg_pb_t        PB_OE,
  output lcdg_pkg::lcdg_pb_t        PB_IN_VAL
);
  import lcdg_pkg::*;

  // ----------------------------------------------------------------
  // Registers and pin state
  // ----------------------------------------------------------------
  lcdg_byte_t pa_data_reg;
  lcdg_byte_t pa_dir_reg;
  lcdg_pb_t   pb_data_reg;
  lcdg_pb_t   pb_dir_reg;
  logic       in_ctl_reg;
  lcdg_byte_t com_sel_reg;
  logic [1:0] col_low_reg;
  logic [2:0] col_high_reg;
  logic       float_en_reg;
  lcdg_byte_t rdata_reg;
  lcdg_byte_t rdata_next;

  lcdg_byte_t pa_meta_reg;
  lcdg_byte_t pa_sync_reg;
  lcdg_pb_t   pb_meta_reg;
  lcdg_pb_t   pb_sync_reg;

  lcdg_byte_t pa_out_reg;
  lcdg_byte_t pa_out_next;
  lcdg_byte_t pa_oe_reg;
  lcdg_byte_t pa_oe_next;
  lcdg_byte_t pa_inv_reg;
  lcdg_byte_t pa_inv_next;
  lcdg_pb_t   pb_out_reg;
  lcdg_pb_t   pb_out_next;
  lcdg_pb_t   pb_oe_reg;
  lcdg_pb_t   pb_oe_next;
  lcdg_pb_t   pb_inv_reg;
  lcdg_pb_t   pb_inv_next;

  lcdg_byte_t pa_lcd_own;
  lcdg_pb_t   pb_sel;
  lcdg_pb_t   pb_lcd_own;
  logic       stby_float;
  logic       stby_hold;
  logic       first_cyc_reg;

  assign pb_sel     = {col_high_reg, col_low_reg};
  assign pa_lcd_own = com_sel_reg & {8{in_ctl_reg}};
  assign pb_lcd_own = pb_sel & {5{in_ctl_reg}};
  assign stby_float = STBY_MODE & float_en_reg;
  assign stby_hold  = STBY_MODE & ~float_en_reg;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pa_meta_reg <= 8'h00;
      pa_sync_reg <= 8'h00;
      pb_meta_reg <= 5'h00;
      pb_sync_reg <= 5'h00;
    end else begin
      pa_meta_reg <= PA_IN;
      pa_sync_reg <= pa_meta_reg;
      pb_meta_reg <= PB_IN;
      pb_sync_reg <= pb_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Port data and direction registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pa_data_reg <= `LCDG_RST_DATA_A;
      pb_data_reg <= `LCDG_RST_DATA_B;
    end else if (WR) begin
      if (ADDR == `LCDG_OFS_PA_DATA) begin
        pa_data_reg <= WDATA;
      end
      if (ADDR == `LCDG_OFS_PB_DATA) begin
        pb_data_reg <= WDATA[4:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pa_dir_reg <= `LCDG_RST_DIR_A;
      pb_dir_reg <= `LCDG_RST_DIR_B;
    end else if (WR) begin
      if (ADDR == `LCDG_OFS_PA_DIR) begin
        pa_dir_reg <= WDATA;
      end
      if (ADDR == `LCDG_OFS_PB_DIR) begin
        pb_dir_reg <= WDATA[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // LCD select and standby control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      in_ctl_reg   <= 1'b0;
      com_sel_reg  <= `LCDG_RST_CTRL;
      col_low_reg  <= 2'h0;
      col_high_reg <= 3'h0;
      float_en_reg <= 1'b0;
    end else if (WR) begin
      unique case (ADDR)
        `LCDG_OFS_LCD_EN1:  in_ctl_reg   <= WDATA[`LCDG_IN_CTL_BIT];
        `LCDG_OFS_LCD_EN2:  com_sel_reg  <= WDATA;
        `LCDG_OFS_LCD_EN3:  col_low_reg  <= WDATA[`LCDG_COL_LOW_MSB:0];
        `LCDG_OFS_LCD_EN7:  col_high_reg <= WDATA[`LCDG_COL_HIGH_MSB:0];
        `LCDG_OFS_STBY_CTL: float_en_reg <= WDATA[`LCDG_FLOAT_BIT];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Input bits come from the gated pin value, so a floated pin reads low
  always_comb begin
    rdata_next = 8'h00;
    if (RD) begin
      unique case (ADDR)
        `LCDG_OFS_PA_DATA: begin
          if (RMW) begin
            rdata_next = pa_data_reg;
          end else begin
            rdata_next = (pa_data_reg & pa_dir_reg) | (pa_inv_reg & ~pa_dir_reg);
          end
        end
        `LCDG_OFS_PB_DATA: begin
          if (RMW) begin
            rdata_next = {3'h0, pb_data_reg};
          end else begin
            rdata_next = {3'h0, (pb_data_reg & pb_dir_reg) | (pb_inv_reg & ~pb_dir_reg)};
          end
        end
        `LCDG_OFS_PA_DIR:   rdata_next = pa_dir_reg;
        `LCDG_OFS_PB_DIR:   rdata_next = {3'h0, pb_dir_reg};
        `LCDG_OFS_LCD_EN1:  rdata_next = {7'h00, in_ctl_reg};
        `LCDG_OFS_LCD_EN2:  rdata_next = com_sel_reg;
        `LCDG_OFS_LCD_EN3:  rdata_next = {6'h00, col_low_reg};
        `LCDG_OFS_LCD_EN7:  rdata_next = {5'h00, col_high_reg};
        `LCDG_OFS_STBY_CTL: rdata_next = {7'h00, float_en_reg};
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and input gating
  // ----------------------------------------------------------------
  // Port drive needs the select bit at 0; LCD drive needs select and input control.
  // Software keeps direction 0 on LCD pins, so LCD drive wins if it does not.
  always_comb begin
    pa_oe_next  = (pa_dir_reg & ~com_sel_reg) | pa_lcd_own;
    pa_out_next = (pa_data_reg & ~pa_lcd_own) | (LCD_COM_LVL & pa_lcd_own);
    pa_inv_next = pa_sync_reg & {8{in_ctl_reg}};
    pb_oe_next  = (pb_dir_reg & ~pb_sel) | pb_lcd_own;
    pb_out_next = (pb_data_reg & ~pb_lcd_own) | (LCD_SEG_LVL & pb_lcd_own);
    pb_inv_next = pb_sync_reg & {5{in_ctl_reg}};
    if (stby_float) begin
      pa_oe_next  = 8'h00;
      pa_out_next = 8'h00;
      pa_inv_next = 8'h00;
      pb_oe_next  = 5'h00;
      pb_out_next = 5'h00;
      pb_inv_next = 5'h00;
    end else if (stby_hold) begin
      pa_oe_next  = pa_oe_reg;
      pa_out_next = pa_out_reg;
      pb_oe_next  = pb_oe_reg;
      pb_out_next = pb_out_reg;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pa_oe_reg  <= 8'h00;
      pa_out_reg <= 8'h00;
      pa_inv_reg <= 8'h00;
      pb_oe_reg  <= 5'h00;
      pb_out_reg <= 5'h00;
      pb_inv_reg <= 5'h00;
    end else begin
      pa_oe_reg  <= pa_oe_next;
      pa_out_reg <= pa_out_next;
      pa_inv_reg <= pa_inv_next;
      pb_oe_reg  <= pb_oe_next;
      pb_out_reg <= pb_out_next;
      pb_inv_reg <= pb_inv_next;
    end
  end

  assign RDATA     = rdata_reg;
  assign PA_OUT    = pa_out_reg;
  assign PA_OE     = pa_oe_reg;
  assign PA_IN_VAL = pa_inv_reg;
  assign PB_OUT    = pb_out_reg;
  assign PB_OE     = pb_oe_reg;
  assign PB_IN_VAL = pb_inv_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      first_cyc_reg <= 1'b1;
    end else begin
      first_cyc_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  a_dir_out_drive: assert property (
    !STBY_MODE && pa_dir_reg == 8'hff && com_sel_reg == 8'h00
      |=> PA_OE == 8'hff && PA_OUT == $past(pa_data_reg))
    else $error("Output bits not driven from latch");

  a_dir_in_float: assert property (
    !STBY_MODE && pb_dir_reg == 5'h00 && pb_sel == 5'h00
      |=> PB_OE == 5'h00)
    else $error("Input bits driven");

  a_write_to_pin: assert property (
    WR && ADDR == `LCDG_OFS_PA_DATA && !STBY_MODE && pa_dir_reg == 8'hff
      && com_sel_reg == 8'h00 ##1 !STBY_MODE && !WR
      |=> PA_OUT == $past(WDATA, 2))
    else $error("Written data not on output pins");

  a_write_latch_in: assert property (
    WR && ADDR == `LCDG_OFS_PB_DATA && pb_dir_reg == 5'h00 && pb_sel == 5'h00
      && !STBY_MODE
      |=> pb_data_reg == $past(WDATA[4:0]) ##1 PB_OE == 5'h00)
    else $error("Latch not updated for input bits");

  a_read_latch_out: assert property (
    RD && ADDR == `LCDG_OFS_PA_DATA && pa_dir_reg == 8'hff
      |=> RDATA == $past(pa_data_reg))
    else $error("Output bits did not read the latch");

  a_rmw_read: assert property (
    RD && RMW && ADDR == `LCDG_OFS_PB_DATA
      |=> RDATA == {3'h0, $past(pb_data_reg)})
    else $error("Read-modify-write did not return latch");

  a_lcd_owns_pin: assert property (
    !STBY_MODE && in_ctl_reg && com_sel_reg == 8'hff
      |=> PA_OE == 8'hff && PA_OUT == $past(LCD_COM_LVL))
    else $error("Backplane select did not hand pin to LCD");

  a_reset_dir: assert property (
    first_cyc_reg |-> pa_dir_reg == 8'h00 && pb_dir_reg == 5'h00 && PA_OE == 8'h00)
    else $error("Direction not cleared by reset");

  a_standby_float: assert property (
    stby_float |=> PA_OE == 8'h00 && PB_OE == 5'h00 && PA_IN_VAL == 8'h00
      && PB_IN_VAL == 5'h00)
    else $error("Pins not floated in standby");

  a_standby_hold: assert property (
    stby_hold [*2] |-> $stable(PA_OE) && $stable(PA_OUT) && $stable(PB_OUT))
    else $error("Pins changed during standby hold");

  a_upper_zero: assert property (
    RD && (ADDR == `LCDG_OFS_PB_DATA || ADDR == `LCDG_OFS_PB_DIR)
      |=> RDATA[7:5] == 3'h0)
    else $error("Port B upper bits not zero");

endmodule // lcdg_ports

// ### tb_top.sv
// Self-checking bench for the LCD-shared port pair.
// Assumes the pin model on the far side and a 10 MHz system clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lcdg_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk_sys = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, rmw = 1'b0, stby = 1'b0;
  logic [7:0] addr = 8'h00;
  lcdg_byte_t wdata = 8'h00, com_lvl = 8'h00, ext_a = 8'h00;
  lcdg_byte_t rdata, pa_in, pa_out, pa_oe, pa_iv;
  lcdg_pb_t   seg_lvl = 5'h00, ext_b = 5'h00;
  lcdg_pb_t   pb_in, pb_out, pb_oe, pb_iv;
  int         n_errors = 0, check_count = 0, cyc = 0;

  always #50 clk_sys = ~clk_sys;

  lcdg_ports dut_u (.CLK_SYS(clk_sys), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RMW(rmw), .RDATA(rdata), .STBY_MODE(stby), .LCD_COM_LVL(com_lvl),
    .LCD_SEG_LVL(seg_lvl), .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe),
    .PA_IN_VAL(pa_iv), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe), .PB_IN_VAL(pb_iv));

  lcdg_pin_model pins_u (.PA_OUT(pa_out), .PA_OE(pa_oe), .EXT_A(ext_a), .PA_IN(pa_in),
    .PB_OUT(pb_out), .PB_OE(pb_oe), .EXT_B(ext_b), .PB_IN(pb_in));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic m, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    rmw <= m;
    @(posedge clk_sys);
    rd <= 1'b0;
    rmw <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Two sync edges plus one output register, and one spare edge
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc(8'h01, 1'b0, 8'h00);
    rdc(8'h03, 1'b0, 8'h00);
    chk(pa_oe, 8'h00);
    chk({3'b000, pb_oe}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_mixed();
    wrt(8'h04, 8'h01);
    ext_a <= 8'h3c;
    wrt(8'h00, 8'ha5);
    wrt(8'h01, 8'h0f);
    settle();
    chk(pa_oe, 8'h0f);
    chk(pa_out & pa_oe, 8'h05);
    rdc(8'h00, 1'b0, 8'h35);
    @(posedge clk_sys);
    #1 chk(rdata, 8'h00);
    rdc(8'h00, 1'b1, 8'ha5);
    chk(pa_iv & 8'hf0, 8'h30);
    wrt(8'h00, 8'h5a);
    settle();
    chk(pa_out & pa_oe, 8'h0a);
    chk(pa_oe, 8'h0f);
    rdc(8'h00, 1'b1, 8'h5a);
    rdc(8'h00, 1'b0, 8'h3a);
    $display("test mixed done");
  endtask

  task automatic t_portb();
    wrt(8'h02, 8'hff);
    wrt(8'h03, 8'hff);
    settle();
    rdc(8'h03, 1'b0, 8'h1f);
    rdc(8'h02, 1'b1, 8'h1f);
    chk({3'b000, pb_oe}, 8'h1f);
    chk({3'b000, pb_out}, 8'h1f);
    wrt(8'h03, 8'h00);
    ext_b <= 5'h0a;
    settle();
    chk({3'b000, pb_oe}, 8'h00);
    rdc(8'h02, 1'b0, 8'h0a);
    $display("test port b done");
  endtask

  task automatic t_lcd();
    wrt(8'h01, 8'h00);
    wrt(8'h05, 8'h81);
    com_lvl <= 8'hc3;
    settle();
    chk(pa_oe, 8'h81);
    chk(pa_out & pa_oe, 8'h81);
    wrt(8'h05, 8'hff);
    settle();
    chk(pa_oe, 8'hff);
    chk(pa_out, 8'hc3);
    wrt(8'h04, 8'h00);
    settle();
    chk(pa_oe, 8'h00);
    wrt(8'h04, 8'h01);
    wrt(8'h06, 8'h01);
    wrt(8'h07, 8'h04);
    seg_lvl <= 5'h1f;
    settle();
    chk({3'b000, pb_oe}, 8'h11);
    chk({3'b000, pb_out & pb_oe}, 8'h11);
    wrt(8'h05, 8'h00);
    wrt(8'h06, 8'h00);
    wrt(8'h07, 8'h00);
    settle();
    chk({3'b000, pb_oe}, 8'h00);
    $display("test lcd done");
  endtask

  task automatic t_standby();
    wrt(8'h00, 8'ha5);
    wrt(8'h01, 8'hff);
    settle();
    @(posedge clk_sys);
    stby <= 1'b1;
    wrt(8'h00, 8'h5a);
    settle();
    chk(pa_out, 8'ha5);
    chk(pa_oe, 8'hff);
    @(posedge clk_sys);
    stby <= 1'b0;
    wrt(8'h08, 8'h01);
    @(posedge clk_sys);
    stby <= 1'b1;
    settle();
    chk(pa_oe, 8'h00);
    chk(pa_out, 8'h00);
    chk(pa_iv, 8'h00);
    chk({3'b000, pb_iv}, 8'h00);
    @(posedge clk_sys);
    stby <= 1'b0;
    wrt(8'h08, 8'h00);
    settle();
    chk(pa_out, 8'h5a);
    wrt(8'h00, 8'hc3);
    settle();
    chk(pa_out, 8'hc3);
    rdc(8'h00, 1'b0, 8'hc3);
    $display("test standby done");
  endtask

  // Reset in mid-run with pins driven
  task automatic t_rereset();
    chk(pa_oe, 8'hff);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1 chk(pa_oe, 8'h00);
    rdc(8'h01, 1'b0, 8'h00);
    rdc(8'h03, 1'b0, 8'h00);
    $display("test rereset done");
  endtask

  task automatic t_unmapped();
    wrt(8'h20, 8'hff);
    rdc(8'h20, 1'b0, 8'h00);
    $display("test unmapped done");
  endtask

  // ----------------------------------------------------------------
  // Verdict and run
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run needs about 150 cycles; ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_mixed();
    t_portb();
    t_lcd();
    t_standby();
    t_rereset();
    t_unmapped();
    give_verdict();
  end
endmodule // tb_top
